// ---- rtl/ssf_flag.sv ----
// one condition: current bit taken at each update, latched bit cleared by read
module ssf_flag (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic update,
  input  wire logic cond,
  input  wire logic clr,
  output logic      cur,
  output logic      lat
);
  logic next_cur;
  logic next_lat;

  always_comb
  begin
    next_cur = update ? cond : cur;
    // set wins over the clear of a read
    next_lat = cur | (lat & ~clr);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur <= 1'b0;
      lat <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
      lat <= next_lat;
    end
  end
endmodule

// ---- rtl/ssf_pkg.sv ----
// package: register map, flag positions and limits of the status word
package ssf_pkg;
  localparam int VAL_W   = 16;
  localparam int WORD_W  = 27;
  localparam int N_COND  = 11;
  localparam int MODE_W  = 2;

  // condition index; word bit 2*i is current, 2*i+1 is latched
  localparam int C_INVALID  = 0;
  localparam int C_UNREL    = 1;
  localparam int C_OFFSCALE = 2;
  localparam int C_HOT      = 3;
  localparam int C_COLD     = 4;
  localparam int C_DRIFT    = 5;
  localparam int C_MAT_HOT  = 6;
  localparam int C_MAT_COLD = 7;
  localparam int C_CAL      = 8;
  localparam int C_FREQAMP  = 9;
  localparam int C_SUPPLY   = 10;

  // measurement modes
  localparam logic [1:0] MODE_F = 2'h1;

  // temperatures in tenths of a degree
  localparam logic signed [15:0] TEMP_HOT_LIMIT  = 16'sh0352;
  localparam logic signed [15:0] TEMP_COLD_LIMIT = 16'sh000A;

  // limit pair layout inside a limit register
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;

  // byte offsets
  localparam logic [7:0] A_STATUS    = 8'h00;
  localparam logic [7:0] A_INCL_UNSC = 8'h04;
  localparam logic [7:0] A_INCL_MOIS = 8'h08;
  localparam logic [7:0] A_AOUT_LIM  = 8'h0C;
  localparam logic [7:0] A_MAT_LIM   = 8'h10;
  localparam logic [7:0] A_CAL_LIM   = 8'h14;
  localparam logic [7:0] A_FREQ_LIM  = 8'h18;
  localparam logic [7:0] A_AMP_LIM   = 8'h1C;
  localparam logic [7:0] A_DRIFT_MAX = 8'h20;
  localparam logic [7:0] A_ALARM_MOD = 8'h24;
  localparam logic [7:0] A_IRQ_STAT  = 8'h28;
  localparam logic [7:0] A_IRQ_MASK  = 8'h2C;

  // reset values
  localparam logic [31:0] RST_LIM  = 32'h7FFF_8000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0]  RST_MODE = 2'h1;
endpackage

// ---- rtl/ssf_range.sv ----
// signed window check: high when value is below lo or above hi
module ssf_range #(
  parameter int W = 16
) (
  input  wire logic signed [W-1:0] value,
  input  wire logic signed [W-1:0] lo,
  input  wire logic signed [W-1:0] hi,
  output logic                     outside
);
  always_comb
  begin
    outside = (value < lo) || (value > hi);
  end
endmodule

// ---- rtl/ssf_status_word.sv ----
// sensor status flag word with ahb-lite limit registers and interrupt
module ssf_status_word #(
  parameter int VW = ssf_pkg::VAL_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  meas_valid,
  input  wire logic [1:0]            meas_mode,
  input  wire logic signed [VW-1:0]  unscaled,
  input  wire logic signed [VW-1:0]  moisture,
  input  wire logic signed [VW-1:0]  aout_value,
  input  wire logic signed [VW-1:0]  elec_temp,
  input  wire logic signed [VW-1:0]  reso_temp,
  input  wire logic signed [VW-1:0]  mat_temp,
  input  wire logic signed [VW-1:0]  freq,
  input  wire logic signed [VW-1:0]  amp,
  input  wire logic [VW-1:0]         drift_dev,
  input  wire logic                  supply_bad,
  output logic [ssf_pkg::WORD_W-1:0] status_word,
  output logic                       irq
);
  localparam int NC = ssf_pkg::N_COND;

  logic [31:0]    r_incl_unsc;
  logic [31:0]    r_incl_mois;
  logic [31:0]    r_aout_lim;
  logic [31:0]    r_mat_lim;
  logic [31:0]    r_cal_lim;
  logic [31:0]    r_freq_lim;
  logic [31:0]    r_amp_lim;
  logic [VW-1:0]  r_drift_max;
  logic [1:0]     r_alarm_mode;
  logic [NC-1:0]  irq_stat;
  logic [NC-1:0]  irq_mask;
  logic           wr_pend;
  logic [7:0]     wr_addr;
  logic [NC-1:0]  cur_q;
  logic [31:0]    next_incl_unsc;
  logic [31:0]    next_incl_mois;
  logic [31:0]    next_aout_lim;
  logic [31:0]    next_mat_lim;
  logic [31:0]    next_cal_lim;
  logic [31:0]    next_freq_lim;
  logic [31:0]    next_amp_lim;
  logic [VW-1:0]  next_drift_max;
  logic [1:0]     next_alarm_mode;
  logic [NC-1:0]  next_irq_stat;
  logic [NC-1:0]  next_irq_mask;
  logic           next_wr_pend;
  logic [7:0]     next_wr_addr;
  logic [31:0]    next_hrdata;
  logic           ap_take;
  logic           rd_status;
  logic [31:0]    rd_mux;
  logic [NC-1:0]  cond;
  logic [NC-1:0]  cur;
  logic [NC-1:0]  lat;
  logic [NC-1:0]  rise;
  logic           out_unsc;
  logic           out_mois;
  logic           out_aout;
  logic           out_cal;
  logic           out_freq;
  logic           out_amp;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // limit window checks
  ssf_range #(.W(VW)) u_incl_unsc (
    .value   (unscaled),
    .lo      (r_incl_unsc[ssf_pkg::LO_LSB +: VW]),
    .hi      (r_incl_unsc[ssf_pkg::HI_LSB +: VW]),
    .outside (out_unsc)
  );
  ssf_range #(.W(VW)) u_incl_mois (
    .value   (moisture),
    .lo      (r_incl_mois[ssf_pkg::LO_LSB +: VW]),
    .hi      (r_incl_mois[ssf_pkg::HI_LSB +: VW]),
    .outside (out_mois)
  );
  ssf_range #(.W(VW)) u_aout (
    .value   (aout_value),
    .lo      (r_aout_lim[ssf_pkg::LO_LSB +: VW]),
    .hi      (r_aout_lim[ssf_pkg::HI_LSB +: VW]),
    .outside (out_aout)
  );
  ssf_range #(.W(VW)) u_cal (
    .value   (unscaled),
    .lo      (r_cal_lim[ssf_pkg::LO_LSB +: VW]),
    .hi      (r_cal_lim[ssf_pkg::HI_LSB +: VW]),
    .outside (out_cal)
  );
  ssf_range #(.W(VW)) u_freq (
    .value   (freq),
    .lo      (r_freq_lim[ssf_pkg::LO_LSB +: VW]),
    .hi      (r_freq_lim[ssf_pkg::HI_LSB +: VW]),
    .outside (out_freq)
  );
  ssf_range #(.W(VW)) u_amp (
    .value   (amp),
    .lo      (r_amp_lim[ssf_pkg::LO_LSB +: VW]),
    .hi      (r_amp_lim[ssf_pkg::HI_LSB +: VW]),
    .outside (out_amp)
  );

  // raw conditions of the present measurement
  always_comb
  begin
    cond = '0;
    cond[ssf_pkg::C_INVALID]  = (meas_mode == ssf_pkg::MODE_F)
                                && (out_unsc || out_mois);
    cond[ssf_pkg::C_UNREL]    = 1'b0;
    cond[ssf_pkg::C_OFFSCALE] = out_aout;
    cond[ssf_pkg::C_HOT]      = elec_temp > ssf_pkg::TEMP_HOT_LIMIT;
    cond[ssf_pkg::C_COLD]     = reso_temp < ssf_pkg::TEMP_COLD_LIMIT;
    cond[ssf_pkg::C_DRIFT]    = drift_dev <= r_drift_max;
    cond[ssf_pkg::C_MAT_HOT]  = mat_temp > $signed(r_mat_lim[ssf_pkg::HI_LSB +: VW]);
    cond[ssf_pkg::C_MAT_COLD] = mat_temp < $signed(r_mat_lim[ssf_pkg::LO_LSB +: VW]);
    cond[ssf_pkg::C_CAL]      = (meas_mode == r_alarm_mode) && out_cal;
    cond[ssf_pkg::C_FREQAMP]  = out_freq || out_amp;
    cond[ssf_pkg::C_SUPPLY]   = supply_bad;
  end

  // per-condition current and latched bits, packed into the word
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_flag
      ssf_flag u_flag (
        .core_clk (core_clk),
        .rstn     (rstn),
        .update   (meas_valid),
        .cond     (cond[gi]),
        .clr      (rd_status),
        .cur      (cur[gi]),
        .lat      (lat[gi])
      );
      assign status_word[2*gi]   = cur[gi];
      assign status_word[2*gi+1] = lat[gi];
    end
  endgenerate
  assign status_word[ssf_pkg::WORD_W-1:2*NC] = '0;

  // bus decode
  always_comb
  begin
    ap_take   = hsel && htrans[1] && hready;
    rd_status = ap_take && !hwrite && (haddr[7:0] == ssf_pkg::A_STATUS)
                && (haddr[31:8] == '0);
    rd_mux    = ssf_pkg::RST_ZERO;
    if (haddr[31:8] != '0)
      rd_mux = ssf_pkg::RST_ZERO;
    else if (haddr[7:0] == ssf_pkg::A_STATUS)
      rd_mux = {{(32-ssf_pkg::WORD_W){1'b0}}, status_word};
    else if (haddr[7:0] == ssf_pkg::A_INCL_UNSC)
      rd_mux = r_incl_unsc;
    else if (haddr[7:0] == ssf_pkg::A_INCL_MOIS)
      rd_mux = r_incl_mois;
    else if (haddr[7:0] == ssf_pkg::A_AOUT_LIM)
      rd_mux = r_aout_lim;
    else if (haddr[7:0] == ssf_pkg::A_MAT_LIM)
      rd_mux = r_mat_lim;
    else if (haddr[7:0] == ssf_pkg::A_CAL_LIM)
      rd_mux = r_cal_lim;
    else if (haddr[7:0] == ssf_pkg::A_FREQ_LIM)
      rd_mux = r_freq_lim;
    else if (haddr[7:0] == ssf_pkg::A_AMP_LIM)
      rd_mux = r_amp_lim;
    else if (haddr[7:0] == ssf_pkg::A_DRIFT_MAX)
      rd_mux = {{(32-VW){1'b0}}, r_drift_max};
    else if (haddr[7:0] == ssf_pkg::A_ALARM_MOD)
      rd_mux = {30'h0000_0000, r_alarm_mode};
    else if (haddr[7:0] == ssf_pkg::A_IRQ_STAT)
      rd_mux = {{(32-NC){1'b0}}, irq_stat};
    else if (haddr[7:0] == ssf_pkg::A_IRQ_MASK)
      rd_mux = {{(32-NC){1'b0}}, irq_mask};
  end

  // register next values
  always_comb
  begin
    rise            = cur & ~cur_q;
    next_wr_pend    = ap_take && hwrite;
    next_wr_addr    = (ap_take && hwrite) ? haddr[7:0] : wr_addr;
    next_hrdata     = (ap_take && !hwrite) ? rd_mux : hrdata;
    next_incl_unsc  = r_incl_unsc;
    next_incl_mois  = r_incl_mois;
    next_aout_lim   = r_aout_lim;
    next_mat_lim    = r_mat_lim;
    next_cal_lim    = r_cal_lim;
    next_freq_lim   = r_freq_lim;
    next_amp_lim    = r_amp_lim;
    next_drift_max  = r_drift_max;
    next_alarm_mode = r_alarm_mode;
    next_irq_mask   = irq_mask;
    next_irq_stat   = irq_stat;
    if (wr_pend)
    begin
      if (wr_addr == ssf_pkg::A_INCL_UNSC)
        next_incl_unsc = hwdata;
      else if (wr_addr == ssf_pkg::A_INCL_MOIS)
        next_incl_mois = hwdata;
      else if (wr_addr == ssf_pkg::A_AOUT_LIM)
        next_aout_lim = hwdata;
      else if (wr_addr == ssf_pkg::A_MAT_LIM)
        next_mat_lim = hwdata;
      else if (wr_addr == ssf_pkg::A_CAL_LIM)
        next_cal_lim = hwdata;
      else if (wr_addr == ssf_pkg::A_FREQ_LIM)
        next_freq_lim = hwdata;
      else if (wr_addr == ssf_pkg::A_AMP_LIM)
        next_amp_lim = hwdata;
      else if (wr_addr == ssf_pkg::A_DRIFT_MAX)
        next_drift_max = hwdata[VW-1:0];
      else if (wr_addr == ssf_pkg::A_ALARM_MOD)
        next_alarm_mode = hwdata[1:0];
      else if (wr_addr == ssf_pkg::A_IRQ_STAT)
        next_irq_stat = irq_stat & ~hwdata[NC-1:0];
      else if (wr_addr == ssf_pkg::A_IRQ_MASK)
        next_irq_mask = hwdata[NC-1:0];
    end
    // event set wins over write-one-to-clear
    next_irq_stat = next_irq_stat | rise;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r_incl_unsc  <= ssf_pkg::RST_LIM;
      r_incl_mois  <= ssf_pkg::RST_LIM;
      r_aout_lim   <= ssf_pkg::RST_LIM;
      r_mat_lim    <= ssf_pkg::RST_LIM;
      r_cal_lim    <= ssf_pkg::RST_LIM;
      r_freq_lim   <= ssf_pkg::RST_LIM;
      r_amp_lim    <= ssf_pkg::RST_LIM;
      r_drift_max  <= '0;
      r_alarm_mode <= ssf_pkg::RST_MODE;
      irq_stat     <= '0;
      irq_mask     <= '0;
      wr_pend      <= 1'b0;
      wr_addr      <= '0;
      hrdata       <= ssf_pkg::RST_ZERO;
      cur_q        <= '0;
      irq          <= 1'b0;
    end
    else
    begin
      r_incl_unsc  <= next_incl_unsc;
      r_incl_mois  <= next_incl_mois;
      r_aout_lim   <= next_aout_lim;
      r_mat_lim    <= next_mat_lim;
      r_cal_lim    <= next_cal_lim;
      r_freq_lim   <= next_freq_lim;
      r_amp_lim    <= next_amp_lim;
      r_drift_max  <= next_drift_max;
      r_alarm_mode <= next_alarm_mode;
      irq_stat     <= next_irq_stat;
      irq_mask     <= next_irq_mask;
      wr_pend      <= next_wr_pend;
      wr_addr      <= next_wr_addr;
      hrdata       <= next_hrdata;
      cur_q        <= cur;
      irq          <= |(next_irq_stat & next_irq_mask);
    end
  end

  // checks
  a_invalid_set: assert property (@(posedge core_clk) disable iff (!rstn)
    meas_valid && meas_mode == ssf_pkg::MODE_F && out_unsc
    |=> status_word[0])
    else $error("invalid flag not set");
  a_invalid_mode: assert property (@(posedge core_clk) disable iff (!rstn)
    meas_valid && meas_mode != ssf_pkg::MODE_F |=> !status_word[0])
    else $error("invalid flag set outside F mode");
  a_unrel_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    !status_word[2] && !status_word[3])
    else $error("unreliable flag set");
  a_hot_limit: assert property (@(posedge core_clk) disable iff (!rstn)
    meas_valid && elec_temp > ssf_pkg::TEMP_HOT_LIMIT |=> ##1 status_word[7])
    else $error("hot flag not latched");
  a_cold_limit: assert property (@(posedge core_clk) disable iff (!rstn)
    meas_valid && reso_temp >= ssf_pkg::TEMP_COLD_LIMIT |=> !status_word[8])
    else $error("cold flag set in range");
  a_supply_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    meas_valid && supply_bad |=> status_word[20])
    else $error("supply flag not set");
  a_read_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_status && !cur[ssf_pkg::C_COLD] |=> !lat[ssf_pkg::C_COLD])
    else $error("latched flag not cleared by read");
  a_relatch: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_status && cur[ssf_pkg::C_HOT] && !meas_valid |=> lat[ssf_pkg::C_HOT])
    else $error("present condition lost on read");
  a_cur_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !meas_valid |=> $stable(cur))
    else $error("current flags moved without update");
endmodule

// ---- verification/ssf_host.sv ----
// ahb-lite master standing in for the polling host
module ssf_host (
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

// ---- verification/ssf_status_word_test.sv ----
// self-checking bench for the status flag word
module ssf_status_word_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [1:0] F = ssf_pkg::MODE_F;

  logic               core_clk = 1'b0;
  logic               rstn = 1'b0;
  logic               hsel, hwrite, hready, hresp, irq;
  logic               meas_valid = 1'b0;
  logic               supply_bad = 1'b0;
  logic [1:0]         meas_mode = 2'h1;
  logic [1:0]         alarm_m = 2'h1;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rd_data;
  logic signed [15:0] unscaled = 16'sh0000, moisture = 16'sh0000, aout_value = 16'sh0000;
  logic signed [15:0] elec_temp = 16'sh0000, reso_temp = 16'sh0064, mat_temp = 16'sh0000;
  logic signed [15:0] freq = 16'sh0000, amp = 16'sh0000;
  logic [15:0]        drift_dev = 16'h0000;
  logic [26:0]        status_word;
  logic [10:0]        cur = 11'h000, lat = 11'h000;
  int                 n_mismatch = 0, compares = 0;

  always #10 core_clk = ~core_clk;

  ssf_host host (.core_clk(core_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  ssf_status_word uut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .meas_valid(meas_valid),
    .meas_mode(meas_mode), .unscaled(unscaled), .moisture(moisture),
    .aout_value(aout_value), .elec_temp(elec_temp), .reso_temp(reso_temp),
    .mat_temp(mat_temp), .freq(freq), .amp(amp), .drift_dev(drift_dev),
    .supply_bad(supply_bad), .status_word(status_word), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // current in even bits, latched in odd bits
  function automatic logic [31:0] word(input logic [10:0] c, input logic [10:0] l);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < 11; i++)
    begin
      w[2*i]   = c[i];
      w[2*i+1] = l[i];
    end
    return w;
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd_data);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, rd_data);
    chk(rd_data, e);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  // status read; latches fall back to what is still present
  task automatic rs;
    rd(32'h0000_0000, word(cur, lat));
    lat = cur;
  endtask

  // one update, k picks the condition to violate, 12 for invalid and cal together, 1 and 15 for none
  task automatic upd(input int k, input logic [1:0] m);
    logic [10:0] nb;
    nb = 11'h020 ^ ((k < 12 && k != 1) ? 11'h001 << (k == 11 ? 9 : k) : 11'h000);
    nb = k == 12 ? 11'h121 : nb;
    nb[ssf_pkg::C_CAL] = nb[ssf_pkg::C_CAL] && (m == alarm_m);
    @(posedge core_clk);
    meas_valid <= 1'b1;
    meas_mode  <= m;
    unscaled   <= k == 8 ? 16'sh0065 : (k == 12 ? 16'shFF37 : 16'sh0000);
    moisture   <= (k == 0 || m != F) ? 16'sh00C8 : 16'sh0000;
    aout_value <= k == 2 ? 16'sh00C8 : 16'sh0000;
    elec_temp  <= k == 3 ? 16'sh0353 : 16'sh0352;
    reso_temp  <= k == 4 ? 16'sh0009 : 16'sh000A;
    drift_dev  <= k == 5 ? 16'h0006 : 16'h0005;
    mat_temp   <= k == 6 ? 16'sh0065 : (k == 7 ? 16'shFF9B : 16'sh0064);
    freq       <= k == 9 ? 16'sh0065 : 16'shFF9C;
    amp        <= k == 11 ? 16'shFF9B : 16'sh0064;
    supply_bad <= k == 10;
    @(posedge core_clk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    cur = nb;
    lat = lat | nb;
    chk({5'h00, status_word}, word(cur, lat));
  endtask

  task automatic ci(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask

  task automatic print_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    chk({5'h00, status_word}, 32'h0000_0000);
    for (int a = 4; a < 32; a += 4)
      rd(32'(a), ssf_pkg::RST_LIM);
    rd(32'h0000_0020, 32'h0000_0000);
    rd(32'h0000_0024, 32'h0000_0001);
    rd(32'h0000_002C, 32'h0000_0000);
    rs;
    // include moisture, aout, material, calibration, freq, amp windows -100..100
    for (int a = 8; a < 32; a += 4)
      wr(32'(a), 32'h0064_FF9C);
    wr(32'h0000_0020, 32'h0000_0005);
    // include unscaled window -200..200, wider than the calibrated span
    wr(32'h0000_0004, 32'h00C8_FF38);
    rd(32'h0000_0004, 32'h00C8_FF38);
    rd(32'h0000_0008, 32'h0064_FF9C);
    for (int k = 0; k < 13; k++)
    begin
      upd(15, F);
      rs;
      rs;
      upd(k, F);
      rs;
      upd(15, F);
      rs;
      rs;
    end
    for (int m = 0; m < 4; m++)
    begin
      wr(32'h0000_0024, 32'(m));
      alarm_m = 2'(m);
      upd(8, 2'(m));
      rs;
      upd(8, 2'(m + 1));
      rs;
    end
    wr(32'h0000_0024, 32'h0000_0001);
    upd(15, F);
    rs;
    ci(1'b0);
    rd(32'h0000_0028, 32'h0000_07FD);
    wr(32'h0000_0028, 32'h0000_07FD);
    rd(32'h0000_0028, 32'h0000_0000);
    wr(32'h0000_002C, 32'h0000_0008);
    ci(1'b0);
    upd(3, F);
    ci(1'b1);
    rd(32'h0000_0028, 32'h0000_0008);
    wr(32'h0000_002C, 32'h0000_0000);
    ci(1'b0);
    wr(32'h0000_002C, 32'h0000_0008);
    ci(1'b1);
    wr(32'h0000_0028, 32'h0000_0008);
    ci(1'b0);
    rd(32'h0000_002C, 32'h0000_0008);
    wr(32'h0000_0040, 32'hFFFF_FFFF);
    rd(32'h0000_0040, 32'h0000_0000);
    rd(32'h0000_0030, 32'h0000_0000);
    print_verdict;
  end

  initial
  begin
    #400_000;
    n_mismatch++;
    print_verdict;
  end
endmodule
